// File: rtl/chg_seq_pkg.sv
// Constants, field layouts and state encoding of the charger power-up sequencer
`default_nettype none
package chg_seq_pkg;
  // Clock rate and sequencing times
  localparam int unsigned CLK_KHZ          = 250000;
  localparam int unsigned REG_DELAY_MS     = 220;
  localparam int unsigned QUAL_MS          = 30;
  localparam int unsigned RETRY_S          = 2;
  localparam int unsigned BOOST_DELAY_MS   = 30;
  localparam int unsigned BOOST_PFM_US     = 100;
  localparam int unsigned REG_DELAY_CYC    = REG_DELAY_MS * CLK_KHZ;
  localparam int unsigned QUAL_CYC         = QUAL_MS * CLK_KHZ;
  localparam int unsigned RETRY_CYC        = RETRY_S * CLK_KHZ * 1000;
  localparam int unsigned BOOST_DELAY_CYC  = BOOST_DELAY_MS * CLK_KHZ;
  localparam int unsigned BOOST_PFM_CYC    = BOOST_PFM_US * CLK_KHZ / 1000;
  // Register byte offsets
  localparam logic [7:0] ADDR_ILIM = 8'h00;
  localparam logic [7:0] ADDR_VLIM = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_EFF  = 8'h10;
  // Control register bit positions, and the voltage limit register's tracking field
  localparam int CTRL_CHG_EN   = 0;
  localparam int CTRL_SRC_EN   = 1;
  localparam int CTRL_LLD      = 2;
  localparam int CTRL_BSW_OFF  = 3;
  localparam int CTRL_SRC_ILIM = 7;
  localparam int VLIM_TRK_LSB  = 8;
  // Current limits in 100 mA steps
  localparam logic [5:0] ILIM_RST  = 6'h05;
  localparam logic [5:0] ILIM_SDP  = 6'h05;
  localparam logic [5:0] ILIM_DCP  = 6'h18;
  localparam logic [5:0] ILIM_UNK  = 6'h05;
  localparam logic [5:0] ILIM_DIV1 = 6'h15;
  localparam logic [5:0] ILIM_DIV2 = 6'h14;
  localparam logic [5:0] ILIM_DIV3 = 6'h0a;
  localparam logic [5:0] ILIM_DIV4 = 6'h18;
  localparam logic [5:0] ILIM_SOFT = 6'h02;
  localparam logic [5:0] ILIM_PFM  = 6'h05;
  // Voltage limit in 50 mV steps, tracking offsets
  localparam logic [6:0] VLIM_RST  = 7'h5a;
  localparam logic [3:0] TRK_OFS1  = 4'h4;
  localparam logic [3:0] TRK_OFS2  = 4'h5;
  localparam logic [3:0] TRK_OFS3  = 4'h6;
  // Source type codes
  localparam logic [2:0] TYPE_NONE  = 3'h0;
  localparam logic [2:0] TYPE_SDP   = 3'h1;
  localparam logic [2:0] TYPE_ADPT  = 3'h2;
  localparam logic [2:0] TYPE_DCP   = 3'h3;
  localparam logic [2:0] TYPE_UNK   = 3'h5;
  localparam logic [2:0] TYPE_BOOST = 3'h7;
  // Synchronised pin indices
  localparam int P_UVLO_OK  = 0;
  localparam int P_IN_PRES  = 1;
  localparam int P_IN_SLEEP = 2;
  localparam int P_IN_OV_OK = 3;
  localparam int P_IN_MIN   = 4;
  localparam int P_BAT_DPL  = 5;
  localparam int P_BAT_BST  = 6;
  localparam int P_TS_OK    = 7;
  localparam int P_BAT_OC   = 8;
  localparam int P_SYS_OK   = 9;
  localparam int P_SDP      = 10;
  localparam int P_DCP      = 11;
  localparam int P_DCD_DONE = 12;
  localparam int P_DP_2P7   = 13;
  localparam int P_DP_2P0   = 14;
  localparam int P_DP_1P2   = 15;
  localparam int P_DM_2P7   = 16;
  localparam int P_DM_2P0   = 17;
  localparam int P_DM_1P2   = 18;
  localparam int PIN_N      = 19;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_HIZ, ST_REG_WAIT, ST_QUAL, ST_RETRY, ST_DETECT,
    ST_VLIM, ST_RUN, ST_BOOST_WAIT, ST_BOOST
  } state_type;
endpackage : chg_seq_pkg
`default_nettype wire

// File: rtl/chg_power_seq.sv
// Charger input power-up sequencer with APB register slave
`timescale 1ns/10ps
`default_nettype none
module chg_power_seq #(
  parameter logic [31:0] REG_DELAY   = chg_seq_pkg::REG_DELAY_CYC,
  parameter logic [31:0] QUAL_TIME   = chg_seq_pkg::QUAL_CYC,
  parameter logic [31:0] RETRY_TIME  = chg_seq_pkg::RETRY_CYC,
  parameter logic [31:0] BOOST_DELAY = chg_seq_pkg::BOOST_DELAY_CYC,
  parameter logic [31:0] BOOST_PFM   = chg_seq_pkg::BOOST_PFM_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        supply_above_uvlo,
  input  wire logic        input_present,
  input  wire logic        input_above_sleep,
  input  wire logic        input_below_ov,
  input  wire logic        input_above_min,
  input  wire logic        battery_above_depletion,
  input  wire logic        battery_above_boost,
  input  wire logic        thermistor_ok,
  input  wire logic        battery_overcurrent,
  input  wire logic        system_above_min,
  input  wire logic        sdp_found,
  input  wire logic        dcp_found,
  input  wire logic        dcd_expired,
  input  wire logic        dp_in_2p7,
  input  wire logic        dp_in_2p0,
  input  wire logic        dp_in_1p2,
  input  wire logic        dm_in_2p7,
  input  wire logic        dm_in_2p0,
  input  wire logic        dm_in_1p2,
  input  wire logic [6:0]  battery_voltage,
  output logic             regulator_enable,
  output logic             test_load_enable,
  output logic             detect_enable,
  output logic             converter_enable,
  output logic             battery_switch_on,
  output logic             boost_enable,
  output logic             boost_pfm,
  output logic             boost_limit_high,
  output logic             pfm_allow,
  output logic             host_event,
  output logic [5:0]       current_limit_eff,
  output logic [7:0]       voltage_limit_eff
);
  import chg_seq_pkg::*;

  // Whole module state in one record
  typedef struct packed {
    logic [PIN_N-1:0] sync1;      // First capture stage of pins
    logic [PIN_N-1:0] sync2;      // Settled pin levels
    logic [6:0]       bat1;       // First capture of battery code
    logic [6:0]       bat2;       // Settled battery code
    state_type        st;         // Sequencer state
    logic [31:0]      cnt;        // Shared delay counter
    logic [5:0]       ilim;       // Input current limit register
    logic [6:0]       vlim;       // Input voltage limit register
    logic [1:0]       track;      // Battery tracking select
    logic             chg_en;     // Charging enabled
    logic             src_en;     // Source mode enable
    logic             lld;        // Light-load mode disable
    logic             src_ilim;   // Boost output limit select
    logic             bsw_off;    // Battery switch forced off
    logic             in_good;    // Input good flag
    logic             pwr_good;   // Power good status
    logic [2:0]       in_type;    // Input type status
    logic             in_seen;    // Input present last cycle
    logic             evt;        // Host event pulse
    logic [31:0]      rdata;      // Read data for the bus
    logic             reg_en;     // Regulator drive
    logic             load_en;    // Test load drive
    logic             det_en;     // Detection drive
    logic             conv_en;    // Converter drive
    logic             bsw_on;     // Battery switch drive
    logic             bst_en;     // Boost drive
    logic             bst_pfm;    // Boost light-load phase
    logic             pfm_ok;     // Buck light-load permit
    logic [5:0]       ilim_eff;   // Applied current limit
    logic [7:0]       vlim_eff;   // Applied voltage limit
  } st_type;

  st_type q;    // Registered state
  st_type n;    // Next state

  // Reset image of the record
  localparam st_type RST_VAL = '{
    sync1: '0, sync2: '0, bat1: '0, bat2: '0, st: ST_HIZ, cnt: '0,
    ilim: ILIM_RST, vlim: VLIM_RST, track: 2'h0, chg_en: 1'b1,
    src_en: 1'b0, lld: 1'b0, src_ilim: 1'b0, bsw_off: 1'b0,
    in_good: 1'b0, pwr_good: 1'b0, in_type: TYPE_NONE, in_seen: 1'b0,
    evt: 1'b0, rdata: '0, reg_en: 1'b0, load_en: 1'b0, det_en: 1'b0,
    conv_en: 1'b0, bsw_on: 1'b0, bst_en: 1'b0, bst_pfm: 1'b0,
    pfm_ok: 1'b0, ilim_eff: ILIM_RST, vlim_eff: {1'b0, VLIM_RST}
  };

  logic [PIN_N-1:0] pins;     // Raw pin vector
  logic [PIN_N-1:0] s;        // Settled pins, short name
  logic             wr_go;    // Write takes effect this edge
  logic             setup;    // Setup phase of a transfer
  logic             mapped;   // Address hits a register
  logic             boost_ok; // All boost entry conditions
  logic             in_ok;    // Regulator input conditions
  logic [3:0]       trk_ofs;  // Selected tracking offset
  logic [7:0]       trk_v;    // Battery plus offset
  logic [31:0]      cnt_inc;  // Counter plus one
  logic [31:0]      stat_w;   // Status word

  // Pins gathered for the synchroniser
  assign pins = {dm_in_1p2, dm_in_2p0, dm_in_2p7, dp_in_1p2, dp_in_2p0,
                 dp_in_2p7, dcd_expired, dcp_found, sdp_found,
                 system_above_min, battery_overcurrent, thermistor_ok,
                 battery_above_boost, battery_above_depletion,
                 input_above_min, input_below_ov, input_above_sleep,
                 input_present, supply_above_uvlo};
  assign s = q.sync2;

  // Bus phase decode; wait states are inserted only while the supply is below UVLO
  assign setup   = psel & ~(penable & pready);  // Setup or wait state: read data kept fresh
  assign mapped  = (paddr == ADDR_ILIM) | (paddr == ADDR_VLIM) |
                   (paddr == ADDR_CTRL) | (paddr == ADDR_STAT) |
                   (paddr == ADDR_EFF);
  // Bus held off while the supply is below its release level
  assign pready  = s[P_UVLO_OK];
  assign pslverr = psel & penable & ~mapped;
  assign wr_go   = psel & penable & pready & pwrite & mapped;
  assign prdata  = q.rdata;

  // Register-driven outputs
  assign regulator_enable  = q.reg_en;
  assign test_load_enable  = q.load_en;
  assign detect_enable     = q.det_en;
  assign converter_enable  = q.conv_en;
  assign battery_switch_on = q.bsw_on;
  assign boost_enable      = q.bst_en;
  assign boost_pfm         = q.bst_pfm;
  assign boost_limit_high  = q.src_ilim;
  assign pfm_allow         = q.pfm_ok;
  assign host_event        = q.evt;
  assign current_limit_eff = q.ilim_eff;
  assign voltage_limit_eff = q.vlim_eff;

  // Status word as software sees it
  assign stat_w = {23'h0, q.bst_en, q.conv_en, q.reg_en, q.bsw_on,
                   q.in_type, q.pwr_good, q.in_good};

  // Entry conditions shared by the sequencer
  assign in_ok    = s[P_IN_PRES] & s[P_IN_SLEEP];
  assign boost_ok = s[P_BAT_BST] & ~s[P_IN_SLEEP] & q.src_en &
                    s[P_TS_OK];
  assign cnt_inc  = q.cnt + 32'h1;

  // Tracking offset chosen by the two-bit field
  always_comb
  begin
    case (q.track)
      2'h1:    trk_ofs = TRK_OFS1;
      2'h2:    trk_ofs = TRK_OFS2;
      2'h3:    trk_ofs = TRK_OFS3;
      default: trk_ofs = 4'h0;
    endcase
    trk_v = {1'b0, q.bat2} + {4'h0, trk_ofs};
  end

  // Next-state logic: sequencer, flags, register writes, read data
  always_comb
  begin
    n = q;
    n.sync1 = pins;
    n.sync2 = q.sync1;
    n.bat1  = battery_voltage;
    n.bat2  = q.bat1;
    n.evt   = 1'b0;
    n.in_seen = s[P_IN_PRES];
    case (q.st)
      // Regulator off, battery carries the system
      ST_HIZ:
      begin
        n.cnt = '0;
        if (in_ok)
        begin
          n.st = ST_REG_WAIT;
        end
        else if (boost_ok)
        begin
          n.st = ST_BOOST_WAIT;
        end
      end
      // Input must hold steady for the whole regulator delay
      ST_REG_WAIT:
      begin
        if (!in_ok)
        begin
          n.st = ST_HIZ;
        end
        else if (cnt_inc >= REG_DELAY)
        begin
          n.st  = ST_QUAL;
          n.cnt = '0;
        end
        else
        begin
          n.cnt = cnt_inc;
        end
      end
      // Test load applied; any dip fails the source
      ST_QUAL:
      begin
        if (!s[P_IN_OV_OK] || !s[P_IN_MIN])
        begin
          n.st  = ST_RETRY;
          n.cnt = '0;
        end
        else if (cnt_inc >= QUAL_TIME)
        begin
          n.st      = ST_DETECT;
          n.in_good = 1'b1;
          n.evt     = 1'b1;
          n.cnt     = '0;
        end
        else
        begin
          n.cnt = cnt_inc;
        end
      end
      // Wait out the retry interval, then qualify again
      ST_RETRY:
      begin
        if (cnt_inc >= RETRY_TIME)
        begin
          n.st  = ST_QUAL;
          n.cnt = '0;
        end
        else
        begin
          n.cnt = cnt_inc;
        end
      end
      // Standard results first; dividers only after DCD timeout
      ST_DETECT:
      begin
        if (s[P_SDP] || s[P_DCP] || s[P_DCD_DONE])
        begin
          n.st       = ST_VLIM;
          n.evt      = 1'b1;
          n.pwr_good = 1'b1;
          n.in_type  = TYPE_ADPT;
          if (s[P_SDP])
          begin
            n.ilim    = ILIM_SDP;
            n.in_type = TYPE_SDP;
          end
          else if (s[P_DCP])
          begin
            n.ilim    = ILIM_DCP;
            n.in_type = TYPE_DCP;
          end
          else if (s[P_DP_2P7] && s[P_DM_2P0])
          begin
            n.ilim = ILIM_DIV1;
          end
          else if (s[P_DP_1P2] && s[P_DM_1P2])
          begin
            n.ilim = ILIM_DIV2;
          end
          else if (s[P_DP_2P0] && s[P_DM_2P7])
          begin
            n.ilim = ILIM_DIV3;
          end
          else if (s[P_DP_2P7] && s[P_DM_2P7])
          begin
            n.ilim = ILIM_DIV4;
          end
          else
          begin
            n.ilim    = ILIM_UNK;
            n.in_type = TYPE_UNK;
          end
        end
      end
      // One cycle for the voltage limit to settle
      ST_VLIM:
      begin
        n.st = ST_RUN;
      end
      // Converter switching
      ST_RUN:
      begin
        n.cnt = '0;
      end
      // Boost conditions must hold through the whole delay
      ST_BOOST_WAIT:
      begin
        if (!boost_ok)
        begin
          n.st = ST_HIZ;
        end
        else if (cnt_inc >= BOOST_DELAY)
        begin
          n.st      = ST_BOOST;
          n.in_type = TYPE_BOOST;
          n.cnt     = '0;
        end
        else
        begin
          n.cnt = cnt_inc;
        end
      end
      // Battery-sourced output; counter times the light-load start
      ST_BOOST:
      begin
        if (!s[P_BAT_BST] || !q.src_en)
        begin
          n.st      = ST_HIZ;
          n.in_type = TYPE_NONE;
          n.cnt     = '0;
        end
        else if (q.cnt < BOOST_PFM)
        begin
          n.cnt = cnt_inc;
        end
      end
      default:
      begin
        n.st = ST_HIZ;
      end
    endcase
    // Losing the input drops any input-side state back to idle
    if (!in_ok && q.st != ST_HIZ && q.st != ST_BOOST_WAIT && q.st != ST_BOOST)
    begin
      n.st       = ST_HIZ;
      n.cnt      = '0;
      n.in_good  = 1'b0;
      n.pwr_good = 1'b0;
      n.in_type  = TYPE_NONE;
    end
    // Host writes win over the detected current limit
    if (wr_go)
    begin
      case (paddr)
        ADDR_ILIM: n.ilim = pwdata[5:0];
        ADDR_VLIM:
        begin
          n.vlim  = pwdata[6:0];
          n.track = pwdata[VLIM_TRK_LSB+1:VLIM_TRK_LSB];
        end
        ADDR_CTRL:
        begin
          n.chg_en   = pwdata[CTRL_CHG_EN];
          n.src_en   = pwdata[CTRL_SRC_EN];
          n.lld      = pwdata[CTRL_LLD];
          n.src_ilim = pwdata[CTRL_SRC_ILIM];
          n.bsw_off  = pwdata[CTRL_BSW_OFF];
        end
        default:
        begin
          n.rdata = n.rdata;
        end
      endcase
    end
    // Fresh attach re-enables the switch; overcurrent still wins
    if (s[P_IN_PRES] && !q.in_seen)
    begin
      n.bsw_off = 1'b0;
    end
    if (s[P_BAT_OC])
    begin
      n.bsw_off = 1'b1;
    end
    // Output drives decoded from the present state
    n.reg_en  = q.st == ST_QUAL || q.st == ST_RETRY || q.st == ST_DETECT ||
                q.st == ST_VLIM || q.st == ST_RUN;
    n.load_en = q.st == ST_QUAL;
    n.det_en  = q.st == ST_DETECT;
    n.conv_en = q.st == ST_RUN;
    n.bst_en  = q.st == ST_BOOST;
    // Switch follows charge enable while charging, else battery level
    if (q.st == ST_RUN)
    begin
      n.bsw_on = ~n.bsw_off & q.chg_en;
    end
    else
    begin
      n.bsw_on = ~n.bsw_off & s[P_BAT_DPL];
    end
    // Soft-start cap while the system rail is low
    if (q.conv_en && !s[P_SYS_OK] && q.ilim > ILIM_SOFT)
    begin
      n.ilim_eff = ILIM_SOFT;
    end
    else
    begin
      n.ilim_eff = q.ilim;
    end
    // Tracking only raises the limit, never lowers it
    if (q.track != 2'h0 && trk_v > {1'b0, q.vlim})
    begin
      n.vlim_eff = trk_v;
    end
    else
    begin
      n.vlim_eff = {1'b0, q.vlim};
    end
    n.pfm_ok  = (q.st == ST_RUN) & ~q.lld & (q.ilim >= ILIM_PFM);
    n.bst_pfm = (q.st == ST_BOOST) & ~q.lld & (q.cnt < BOOST_PFM);
    // Undervoltage clears everything but the pin capture
    if (!s[P_UVLO_OK])
    begin
      n       = RST_VAL;
      n.sync1 = pins;
      n.sync2 = q.sync1;
      n.bat1  = battery_voltage;
      n.bat2  = q.bat1;
    end
    // Read data refreshed until the access ends; after the undervoltage
    // clear so a transfer held off by pready still returns live values
    if (setup)
    begin
      case (paddr)
        ADDR_ILIM: n.rdata = {26'h0, q.ilim};
        ADDR_VLIM: n.rdata = {22'h0, q.track, 1'b0, q.vlim};
        ADDR_CTRL: n.rdata = {24'h0, q.src_ilim, 3'h0, q.bsw_off,
                              q.lld, q.src_en, q.chg_en};
        ADDR_STAT: n.rdata = stat_w;
        ADDR_EFF:  n.rdata = {16'h0, q.vlim_eff, 2'h0, q.ilim_eff};
        default:   n.rdata = '0;
      endcase
    end
  end

  // Single state register; async reset loads constants only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= RST_VAL;
    end
    else
    begin
      q <= n;
    end
  end

endmodule : chg_power_seq
`default_nettype wire

// File: testbench/chg_seq_asserts.sv
// Port-level checker for the charger power-up sequencer
`timescale 1ns/10ps
`default_nettype none
module chg_seq_asserts
  import chg_seq_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       input_present,
  input wire logic       input_above_sleep,
  input wire logic       battery_above_boost,
  input wire logic       battery_overcurrent,
  input wire logic       system_above_min,
  input wire logic       regulator_enable,
  input wire logic       test_load_enable,
  input wire logic       detect_enable,
  input wire logic       converter_enable,
  input wire logic       battery_switch_on,
  input wire logic       boost_enable,
  input wire logic       boost_pfm,
  input wire logic       pfm_allow,
  input wire logic       host_event,
  input wire logic [5:0] current_limit_eff
);
  // One clock domain; figures assume the bench's short counts (20, 10, 8)
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_event_pulse: assert property (host_event |=> !host_event)
    else $error("event pin high for more than one cycle");
  a_reg_delay: assert property ($rose(regulator_enable) && input_present |->
    $past(input_present, 20) && $past(input_above_sleep, 20)) else $error("regulator enabled too early");
  a_load_on_reg: assert property (test_load_enable |-> regulator_enable)
    else $error("test load without regulator");
  a_detect_order: assert property (detect_enable |-> regulator_enable && !converter_enable)
    else $error("detection out of order");
  a_conv_order: assert property (converter_enable |-> regulator_enable && !test_load_enable)
    else $error("converter out of order");
  a_soft_cap: assert property ((converter_enable && !system_above_min) [*4] |->
    current_limit_eff <= ILIM_SOFT) else $error("soft-start cap missing");
  a_pfm_gate: assert property (pfm_allow |-> converter_enable)
    else $error("light-load mode outside converter run");
  a_oc_opens: assert property (battery_overcurrent [*4] |-> !battery_switch_on)
    else $error("battery switch closed on overcurrent");
  a_boost_start: assert property ($rose(boost_enable) |->
    $past(battery_above_boost, 10) && !$past(input_above_sleep, 10)) else $error("boost started early");
  a_boost_exit: assert property (!battery_above_boost [*5] |-> !boost_enable)
    else $error("boost kept on low battery");
  a_boost_pfm: assert property (boost_pfm [*8] |=> !boost_pfm)
    else $error("boost light-load phase too long");
endmodule : chg_seq_asserts
bind chg_power_seq chg_seq_asserts chk (.*);
`default_nettype wire

// File: testbench/chg_src_model.sv
// Input source model: supply levels and D+/D- answers
`timescale 1ns/10ps
`default_nettype none
module chg_src_model (
  input  wire logic       pclk,
  input  wire logic       attach,
  input  wire logic [2:0] kind,
  input  wire logic [3:0] dly,
  input  wire logic       detect_enable,
  input  wire logic       test_load_enable,
  output logic            input_present,
  output logic            input_below_ov,
  output logic            input_above_min,
  output logic            sdp_found,
  output logic            dcp_found,
  output logic            dcd_expired,
  output logic            dp_in_2p7,
  output logic            dp_in_2p0,
  output logic            dp_in_1p2,
  output logic            dm_in_2p7,
  output logic            dm_in_2p0,
  output logic            dm_in_1p2
);
  logic [4:0] wait_ff; // Cycles since detection began, saturating
  logic       done;    // Random stall over: the answer shows
  always_ff @(posedge pclk) wait_ff <= detect_enable ? wait_ff + {4'h0, !done} : 5'h00;
  assign done            = detect_enable && wait_ff > {1'b0, dly};
  assign input_present   = attach;
  assign input_below_ov  = attach;
  // A poor source sags once the test load is on
  assign input_above_min = attach && !(kind == 3'h7 && test_load_enable);
  assign sdp_found   = done && kind == 3'h0;
  assign dcp_found   = done && kind == 3'h1;
  assign dcd_expired = done && kind > 3'h1;
  // Divider windows; lines read low when detached
  assign dp_in_2p7 = attach && (kind == 3'h2 || kind == 3'h5);
  assign dp_in_2p0 = attach && kind == 3'h4;
  assign dp_in_1p2 = attach && kind == 3'h3;
  assign dm_in_2p7 = attach && (kind == 3'h4 || kind == 3'h5);
  assign dm_in_2p0 = attach && kind == 3'h2;
  assign dm_in_1p2 = attach && kind == 3'h3;
endmodule : chg_src_model
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the charger power-up sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
  import chg_seq_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, attach = 1'b0;
  logic supply_above_uvlo = 1'b1, battery_above_depletion = 1'b1, battery_above_boost = 1'b0;
  logic thermistor_ok = 1'b0, battery_overcurrent = 1'b0, system_above_min = 1'b1, input_above_sleep;
  logic [7:0] paddr = 8'h00, vexp, ofs;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [6:0] battery_voltage = 7'h40;
  logic [2:0] kind = 3'h0;
  logic [3:0] dly = 4'h3;
  logic [5:0] lim, current_limit_eff;
  logic [7:0] voltage_limit_eff;
  logic pready, pslverr, input_present, input_below_ov, input_above_min, sdp_found, dcp_found, dcd_expired;
  logic dp_in_2p7, dp_in_2p0, dp_in_1p2, dm_in_2p7, dm_in_2p0, dm_in_1p2, regulator_enable, test_load_enable;
  logic detect_enable, converter_enable, battery_switch_on, boost_enable, boost_pfm, boost_limit_high;
  logic pfm_allow, host_event;
  logic [31:0] exp_q[$], msk_q[$]; // Expected read data and compare masks
  int err_total = 0, samples_checked = 0, cyc = 0, ev_cnt = 0, ev0 = 0;
  logic [5:0] ilim_tab [8] = '{ILIM_SDP, ILIM_DCP, ILIM_DIV1, ILIM_DIV2, ILIM_DIV3, ILIM_DIV4, ILIM_UNK, ILIM_SDP};
  logic [2:0] type_tab [8] = '{TYPE_SDP, TYPE_DCP, TYPE_ADPT, TYPE_ADPT, TYPE_ADPT, TYPE_ADPT, TYPE_UNK, TYPE_SDP};
  assign input_above_sleep = input_present; // Attached source stands above battery
  always #2 pclk = ~pclk;
  chg_power_seq #(.REG_DELAY(32'd20), .QUAL_TIME(32'd10), .RETRY_TIME(32'd30), .BOOST_DELAY(32'd10),
    .BOOST_PFM(32'd8)) uut (.*);
  chg_src_model src (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      err_total++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask : check
  // One APB transfer; on reads d is the expected word, m its mask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
    begin
      exp_q.push_back(d);
      msk_q.push_back(m);
    end
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    check({31'h0, pslverr}, {31'h0, !(a inside {ADDR_ILIM, ADDR_VLIM, ADDR_CTRL, ADDR_STAT, ADDR_EFF})});
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Read status until the masked bits match, bounded
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do apb(1'b0, ADDR_STAT, 32'h0, 32'h0); while ((rd & m) !== v && ++n < 100);
    if ((rd & m) !== v) check(rd & m, v);
  endtask : poll
  task automatic close_out;
    if (err_total == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // Scoreboard: each completed read takes the oldest note
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
    begin
      if (msk_q[0] != 32'h0) check(prdata & msk_q[0], exp_q[0] & msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    if (host_event === 1'b1) ev_cnt++;
    if (++cyc == 20000)
    begin
      err_total++;
      close_out();
    end
  end
  initial
  begin
    rd = $urandom(32'he3440fb6);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, ADDR_ILIM, {26'h0, ILIM_RST}, 32'h3f);
    apb(1'b0, ADDR_VLIM, {25'h0, VLIM_RST}, 32'h37f);
    apb(1'b0, ADDR_CTRL, 32'h1, 32'h8f);
    apb(1'b0, ADDR_STAT, 32'h20, 32'h1ff);
    apb(1'b0, 8'h14, 32'h0, 32'hffffffff);
    battery_overcurrent <= 1'b1;
    repeat (6) @(posedge pclk);
    battery_overcurrent <= 1'b0;
    apb(1'b0, ADDR_CTRL, 32'h8, 32'h8);
    apb(1'b0, ADDR_STAT, 32'h0, 32'h20);
    // Every source kind; the last is poor at first, then recovers
    for (int k = 0; k < 8; k++)
    begin
      ev0 = ev_cnt;
      dly <= 4'($urandom_range(15));
      kind <= 3'(k);
      attach <= 1'b1;
      if (k == 7)
      begin
        repeat (40) @(posedge pclk);
        apb(1'b0, ADDR_STAT, 32'h0, 32'h1);
        kind <= 3'h0;
      end
      poll(32'h80, 32'h80);
      check(ev_cnt - ev0, 32'h2);
      apb(1'b0, ADDR_STAT, 32'he3 | {27'h0, type_tab[k], 2'b00}, 32'hff);
      apb(1'b0, ADDR_ILIM, {26'h0, ilim_tab[k]}, 32'h3f);
      apb(1'b0, ADDR_CTRL, 32'h0, 32'h8);
      if (k < 7)
      begin
        attach <= 1'b0;
        poll(32'hc0, 32'h0);
      end
    end
    for (int i = 0; i < 4; i++)
    begin
      lim = (i < 2) ? 6'(4 + i) : 6'($urandom_range(63));
      apb(1'b1, ADDR_ILIM, {26'h0, lim}, 32'h0);
      apb(1'b1, ADDR_CTRL, {29'h0, i[1], 2'b01}, 32'h0);
      repeat (3) @(posedge pclk);
      check({31'h0, pfm_allow}, {31'h0, lim >= ILIM_PFM && !i[1]});
      apb(1'b0, ADDR_EFF, {26'h0, lim}, 32'h3f);
      system_above_min <= 1'b0;
      repeat (6) @(posedge pclk);
      apb(1'b0, ADDR_EFF, {26'h0, (lim < ILIM_SOFT) ? lim : ILIM_SOFT}, 32'h3f);
      system_above_min <= 1'b1;
    end
    for (int t = 0; t < 4; t++)
    begin
      battery_voltage <= 7'($urandom_range(127));
      apb(1'b1, ADDR_VLIM, {22'h0, 2'(t), 8'h50}, 32'h0);
      repeat (4) @(posedge pclk);
      ofs = (t == 1) ? {4'h0, TRK_OFS1} : (t == 2) ? {4'h0, TRK_OFS2} : {4'h0, TRK_OFS3};
      vexp = (t != 0 && {1'b0, battery_voltage} + ofs > 8'h50) ? {1'b0, battery_voltage} + ofs : 8'h50;
      apb(1'b0, ADDR_EFF, {16'h0, vexp, 8'h0}, 32'hff00);
    end
    apb(1'b1, ADDR_CTRL, 32'h0, 32'h0);
    repeat (3) @(posedge pclk);
    apb(1'b0, ADDR_STAT, 32'h80, 32'ha0);
    attach <= 1'b0;
    thermistor_ok <= 1'b1;
    battery_above_boost <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h83, 32'h0);
    poll(32'h100, 32'h100);
    apb(1'b0, ADDR_STAT, 32'h11c, 32'h11c);
    check({31'h0, boost_limit_high}, 32'h1);
    battery_above_boost <= 1'b0;
    poll(32'h100, 32'h0);
    supply_above_uvlo <= 1'b0;
    repeat (4) @(posedge pclk);
    supply_above_uvlo <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h1, 32'h8f);
    close_out();
  end
endmodule : tb
`default_nettype wire
